// [rtl/csm_clock_switch.sv]
// clock switch sequencer and fail-safe clock monitor
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
// Notes on behaviour
// - software may select any of eight sources
// - primary submode fixed by configuration only
// - switch and monitor enabled when bit zero
// - disabled: selection ignored, status shows initial
// - disabled: switch request reads zero always
// - byte writes accepted only after unlock
// - equal sources: clear request, abort switch
// - valid switch clears lock and fail flags
// - start new oscillator, crystal waits start timer
// - pll sources wait for pll lock
// - ten new-clock cycles before changeover
// - completion clears request, copies source status
// - old source off, with low_power_rc_osc/secondary exceptions
// - processor keeps running during switch
// - monitor keeps low_power_rc_osc running except sleep
// - failure raises trap, falls to fast rc
// - failed pll config falls to fast rc pll
// - source code encoding is fixed
`timescale 1ns/1ps
`include "csm_params.svh"

module csm_clock_switch (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // configuration bits
  input wire logic switch_monitor_cfg,
  input wire csm_pkg::csm_src_t initial_source_cfg,
  input wire logic [1:0] primary_submode_cfg,
  input wire logic secondary_keep_on,
  input wire logic watchdog_enable,
  input wire logic sleep_mode,
  // control register writes
  input wire csm_pkg::csm_wr_s ctrlWr,
  // oscillator feedback, synchronous to core_clk
  input wire logic [7:0] oscRunning,
  input wire logic osc_startup_timer_done,
  input wire logic pllLocked,
  input wire logic newClkTick,
  input wire logic activeClkEdge,
  input wire logic lprcTick,
  // outputs
  output csm_pkg::csm_status_s status,
  output csm_pkg::csm_src_t sysClkSel,
  output logic [7:0] oscEnable,
  output logic [1:0] primarySubmode,
  output logic clockFailTrap,
  output logic cpuRun
);
  import csm_pkg::*;

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  function automatic logic usesPll(input csm_src_t s);
    usesPll = (s == `CSM_SRC_FRC_PLL) || (s == `CSM_SRC_PRI_PLL);
  endfunction : usesPll

  // one oscillator slot per family: 0 fast rc, 2 primary, 4 secondary, 5 low_power_rc_osc
  function automatic logic [7:0] oscOf(input csm_src_t s);
    logic [7:0] v;
    v = 8'h00;
    unique case (s)
      `CSM_SRC_PRI, `CSM_SRC_PRI_PLL: v[2] = 1'b1;
      `CSM_SRC_SEC: v[4] = 1'b1;
      `CSM_SRC_LOW_POWER_RC_OSC: v[5] = 1'b1;
      default: v[0] = 1'b1;
    endcase
    oscOf = v;
  endfunction : oscOf

  logic swEn;
  assign swEn = ~switch_monitor_cfg;

  //------------------------------------------------------------
  // unlock sequence
  //------------------------------------------------------------
  logic [1:0] unlockStep_q;
  logic anyWr;
  logic unlocked;
  assign anyWr = ctrlWr.wrHigh | ctrlWr.wrLow;
  assign unlocked = (unlockStep_q == 2'h2);

  // key pair then one protected write
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      unlockStep_q <= 2'h0;
    end else if (anyWr) begin
      if (unlockStep_q == 2'h0 && ctrlWr.wrLow && ctrlWr.data == `CSM_KEY1) begin
        unlockStep_q <= 2'h1;
      end else if (unlockStep_q == 2'h1 && ctrlWr.wrLow && ctrlWr.data == `CSM_KEY2) begin
        unlockStep_q <= 2'h2;
      end else begin
        unlockStep_q <= 2'h0;
      end
    end
  end

  //------------------------------------------------------------
  // sequencer
  //------------------------------------------------------------
  csm_state_e state_q;
  csm_src_t requested_q;
  csm_src_t current_q;
  logic switchReq_q;
  logic lock_q;
  logic fail_q;
  logic [3:0] cnt_q;
  logic [3:0] failCnt_q;
  logic failNow;

  // timeout counted on low-power rc ticks
  assign failNow = swEn && (failCnt_q == `CSM_FAIL_TICKS) && !sleep_mode;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      failCnt_q <= 4'h0;
    end else if (activeClkEdge || !swEn || state_q != CSM_IDLE || failNow) begin
      // restart after a trap so the trap is a one-cycle pulse that repeats each timeout, not a stuck trap
      failCnt_q <= 4'h0;
    end else if (lprcTick && failCnt_q != `CSM_FAIL_TICKS) begin
      failCnt_q <= failCnt_q + 4'h1;
    end
  end

  // requested source written only right after unlock
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      requested_q <= `CSM_RESET_SRC;
    end else if (unlocked && ctrlWr.wrHigh && state_q == CSM_IDLE) begin
      requested_q <= ctrlWr.data[2:0];
    end
  end

  //------------------------------------------------------------
  // decoded events
  //------------------------------------------------------------
  logic reqStrobe;
  logic redundant;
  logic newOscReady;
  logic newPllReady;
  logic countDone;
  logic [7:0] newOscSlot;
  assign reqStrobe = unlocked && ctrlWr.wrLow && ctrlWr.data[0];
  assign redundant = (requested_q == current_q);
  assign newOscSlot = oscOf(requested_q);
  assign newOscReady = ((newOscSlot & oscRunning) != 8'h00) &&
                       (!newOscSlot[2] || primary_submode_cfg == 2'h3 || osc_startup_timer_done);
  assign newPllReady = !usesPll(requested_q) || pllLocked;
  assign countDone = newClkTick && (cnt_q == `CSM_NEW_CLK_CYCLES - 4'h1);

  //------------------------------------------------------------
  // state register
  //------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n || !swEn) begin
      state_q <= CSM_IDLE;
    end else begin
      unique case (state_q)
        CSM_IDLE: begin
          if (!failNow && reqStrobe) begin
            state_q <= CSM_CHECK;
          end
        end
        CSM_CHECK: begin
          state_q <= redundant ? CSM_IDLE : CSM_START;
        end
        CSM_START: begin
          if (newOscReady) begin
            state_q <= CSM_LOCK;
          end
        end
        CSM_LOCK: begin
          if (newPllReady) begin
            state_q <= CSM_COUNT;
          end
        end
        CSM_COUNT: begin
          if (countDone) begin
            state_q <= CSM_DONE;
          end
        end
        CSM_DONE: begin
          state_q <= CSM_IDLE;
        end
        default: begin
          state_q <= CSM_IDLE;
        end
      endcase
    end
  end

  //------------------------------------------------------------
  // status flags and counters
  //------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      switchReq_q <= 1'b0;
    end else if (!swEn) begin
      switchReq_q <= 1'b0;
    end else if (state_q == CSM_IDLE && !failNow && reqStrobe) begin
      switchReq_q <= 1'b1;
    end else if ((state_q == CSM_CHECK && redundant) || state_q == CSM_DONE) begin
      switchReq_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      current_q <= `CSM_RESET_SRC;
    end else if (!swEn) begin
      current_q <= initial_source_cfg;
    end else if (state_q == CSM_IDLE && failNow) begin
      current_q <= usesPll(current_q) ? `CSM_SRC_FRC_PLL : `CSM_SRC_FRC;
    end else if (state_q == CSM_DONE) begin
      current_q <= requested_q;
    end
  end

  // lock follows the pll only while idle; a cleared flag stays clear during a switch until the lock state loads it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lock_q <= 1'b0;
    end else if (swEn && state_q == CSM_CHECK && !redundant) begin
      lock_q <= 1'b0;
    end else if (swEn && state_q == CSM_LOCK && newPllReady) begin
      lock_q <= usesPll(requested_q);
    end else if (state_q == CSM_IDLE && usesPll(current_q)) begin
      lock_q <= pllLocked;
    end
  end

  // failure is only seen while idle, so set and clear never meet
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fail_q <= 1'b0;
    end else if (state_q == CSM_IDLE && failNow) begin
      fail_q <= 1'b1;
    end else if (swEn && state_q == CSM_CHECK && !redundant) begin
      fail_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      clockFailTrap <= 1'b0;
    end else begin
      clockFailTrap <= (state_q == CSM_IDLE) && failNow;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_q <= 4'h0;
    end else if (state_q == CSM_LOCK) begin
      cnt_q <= 4'h0;
    end else if (state_q == CSM_COUNT && newClkTick) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  //------------------------------------------------------------
  // oscillator enables
  //------------------------------------------------------------
  logic [7:0] curSlot;
  wire logic [7:0] keep;
  logic lprcHold;
  logic busy;
  assign curSlot = oscOf(current_q);
  // new source powers up while the sequence runs
  assign busy = (state_q != CSM_IDLE) && (state_q != CSM_CHECK);
  assign lprcHold = (swEn || watchdog_enable) && !sleep_mode;

  for (genvar i = 0; i < 8; i++) begin : g_slot
    logic hold;
    if (i == 5) begin : g_low_power_rc_osc
      assign hold = lprcHold;
    end else if (i == 4) begin : g_sec
      assign hold = secondary_keep_on;
    end else begin : g_plain
      assign hold = 1'b0;
    end
    assign keep[i] = curSlot[i] | (busy & newOscSlot[i]) | hold;
  end

  //------------------------------------------------------------
  // registered outputs
  //------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      oscEnable <= 8'h21;
    end else begin
      oscEnable <= keep;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sysClkSel <= `CSM_RESET_SRC;
      status <= '0;
    end else begin
      sysClkSel <= current_q;
      status <= '{current: current_q, requested: requested_q, switchReq: switchReq_q,
                  pllLock: lock_q, clockFail: fail_q};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      primarySubmode <= 2'h0;
    end else begin
      primarySubmode <= primary_submode_cfg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cpuRun <= 1'b0;
    end else begin
      cpuRun <= 1'b1;
    end
  end
endmodule : csm_clock_switch

// [rtl/csm_params.svh]
// constants for the clock switch and fail-safe monitor
`ifndef CSM_PARAMS_SVH
`define CSM_PARAMS_SVH
// source codes
`define CSM_SRC_FRC 3'h0
`define CSM_SRC_FRC_PLL 3'h1
`define CSM_SRC_PRI 3'h2
`define CSM_SRC_PRI_PLL 3'h3
`define CSM_SRC_SEC 3'h4
`define CSM_SRC_LOW_POWER_RC_OSC 3'h5
`define CSM_SRC_FRC_DIV16 3'h6
`define CSM_SRC_FRC_POST 3'h7
// unlock keys, written to the control register in this order
`define CSM_KEY1 8'h46
`define CSM_KEY2 8'h57
// cycles of the new clock before changeover
`define CSM_NEW_CLK_CYCLES 4'hA
// fail timeout, in low-power rc ticks
`define CSM_FAIL_TICKS 4'h4
// reset values
`define CSM_RESET_SRC 3'h0
`endif

// [rtl/csm_pkg.sv]
// types for the clock switch and fail-safe monitor
package csm_pkg;
  typedef logic [2:0] csm_src_t;
  typedef enum logic [6:0] {
    CSM_IDLE = 7'h01,
    CSM_CHECK = 7'h02,
    CSM_START = 7'h04,
    CSM_LOCK = 7'h08,
    CSM_COUNT = 7'h10,
    CSM_DONE = 7'h20,
    CSM_FAIL = 7'h40
  } csm_state_e;
  typedef struct packed {
    logic wrHigh;
    logic wrLow;
    logic [7:0] data;
  } csm_wr_s;
  typedef struct packed {
    csm_src_t current;
    csm_src_t requested;
    logic switchReq;
    logic pllLock;
    logic clockFail;
  } csm_status_s;
endpackage : csm_pkg

// [dv/csm_clock_switch_chk.sv]
// assertions for the clock switch sequencer
`timescale 1ns/1ps
`include "csm_params.svh"
module csm_clock_switch_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // configuration
  input wire logic switch_monitor_cfg,
  input wire csm_pkg::csm_src_t initial_source_cfg,
  input wire logic [1:0] primary_submode_cfg,
  input wire logic sleep_mode,
  // outputs
  input wire csm_pkg::csm_status_s status,
  input wire csm_pkg::csm_src_t sysClkSel,
  input wire logic [7:0] oscEnable,
  input wire logic [1:0] primarySubmode,
  input wire logic clockFailTrap,
  input wire logic cpuRun
);
  import csm_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence held_in_reset; !reset_n [*2]; endsequence
  sequence switch_ends; $fell(status.switchReq); endsequence
  sequence trap_fires; $rose(clockFailTrap); endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  reset_values_a: assert property (disable iff (1'b0) held_in_reset |->
    status == '0 && oscEnable == 8'h21 && !clockFailTrap) else $error("reset values wrong");
  off_no_req_a: assert property (switch_monitor_cfg |-> !status.switchReq)
    else $error("request seen while disabled");
  off_init_src_a: assert property (switch_monitor_cfg [*4] |-> status.current == initial_source_cfg)
    else $error("current source not initial");
  switch_copy_a: assert property (switch_ends |-> status.current == status.requested)
    else $error("current source not copied");
  trap_pulse_a: assert property (trap_fires |=> !clockFailTrap)
    else $error("trap longer than one cycle");
  fail_to_rc_a: assert property (trap_fires |-> ##[0:3]
    (sysClkSel == `CSM_SRC_FRC || sysClkSel == `CSM_SRC_FRC_PLL)) else $error("no fast rc failover");
  low_power_rc_osc_kept_a: assert property ((!switch_monitor_cfg && !sleep_mode) [*3] |-> oscEnable[5])
    else $error("low-power rc stopped");
  submode_fixed_a: assert property ($stable(primary_submode_cfg) [*3] |->
    primarySubmode == primary_submode_cfg) else $error("submode differs");
  cpu_runs_a: assert property (reset_n [*3] |-> cpuRun)
    else $error("processor stopped");
endmodule : csm_clock_switch_chk

bind csm_clock_switch csm_clock_switch_chk u_chk (.core_clk, .reset_n, .switch_monitor_cfg,
  .initial_source_cfg, .primary_submode_cfg, .sleep_mode, .status, .sysClkSel, .oscEnable,
  .primarySubmode, .clockFailTrap, .cpuRun);

// [dv/tb_top.sv]
// self-checking bench for the clock switch sequencer
`timescale 1ns/1ps
`include "csm_params.svh"
module tb_top;
  import csm_pkg::*;
  logic core_clk = 1'b0, reset_n = 1'b0, switch_monitor_cfg = 1'b1;
  csm_src_t initial_source_cfg = `CSM_SRC_PRI;
  csm_wr_s ctrlWr = '0;
  logic [7:0] oscRunning = 8'h21;
  logic osc_startup_timer_done = 1'b0, pllLocked = 1'b0, newClkTick = 1'b0;
  logic activeClkEdge = 1'b0, lprcTick = 1'b0, actOn = 1'b1, trapSeen;
  logic [3:0] tick = 4'h0;
  csm_status_s status;
  csm_src_t sysClkSel;
  logic [7:0] oscEnable;
  logic [1:0] primarySubmode;
  logic clockFailTrap, cpuRun;
  int numErrors = 0, checked = 0, ticks;
  // ----------------------------------------
  // clock, oscillator feedback, design
  // ----------------------------------------
  always #10 core_clk = ~core_clk;
  // low_power_rc_osc runs slower than the new clock so the timeout spans several core cycles
  always @(negedge core_clk) begin
    tick <= tick + 4'h1;
    lprcTick <= (tick[1:0] == 2'h3);
    newClkTick <= tick[0];
    activeClkEdge <= actOn;
  end
  csm_clock_switch uut (.core_clk, .reset_n, .switch_monitor_cfg, .initial_source_cfg,
    .primary_submode_cfg(2'h0), .secondary_keep_on(1'b0), .watchdog_enable(1'b0), .sleep_mode(1'b0),
    .ctrlWr, .oscRunning, .osc_startup_timer_done, .pllLocked, .newClkTick, .activeClkEdge,
    .lprcTick, .status, .sysClkSel, .oscEnable, .primarySubmode, .clockFailTrap, .cpuRun);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic waitc(int n);
    repeat (n) @(negedge core_clk);
  endtask : waitc
  // writes stay back to back so the unlock is never broken by a held write repeating in a gap
  task automatic wr(logic hi, logic lo, logic [7:0] d);
    @(negedge core_clk);
    ctrlWr <= '{hi, lo, d};
  endtask : wr
  task automatic prot(logic hi, logic [7:0] d);
    wr(1'b0, 1'b1, `CSM_KEY1);
    wr(1'b0, 1'b1, `CSM_KEY2);
    wr(hi, !hi, d);
    wr(1'b0, 1'b0, 8'h00);
  endtask : prot
  task automatic do_reset(logic off);
    @(negedge core_clk);
    reset_n <= 1'b0;
    switch_monitor_cfg <= off;
    waitc(4);
    reset_n <= 1'b1;
    waitc(4);
  endtask : do_reset
  task endSim;
    $display("checks %0d errors %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : endSim
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    waitc(3000);
    numErrors++;
    endSim();
  end
  initial begin
    do_reset(1'b1);
    chk("cpuRun", 8'(cpuRun), 8'h01);
    prot(1'b1, 8'h04);
    prot(1'b0, 8'h01);
    waitc(3);
    chk("switchReq", 8'(status.switchReq), 8'h00);
    chk("current", 8'(status.current), 8'(initial_source_cfg));
    do_reset(1'b0);
    chk("oscEnable", oscEnable, 8'h21);
    wr(1'b1, 1'b0, 8'h04);
    wr(1'b0, 1'b1, `CSM_KEY1);
    wr(1'b0, 1'b1, 8'h00);
    wr(1'b0, 1'b1, `CSM_KEY2);
    wr(1'b1, 1'b0, 8'h04);
    wr(1'b0, 1'b0, 8'h00);
    waitc(3);
    chk("requested", 8'(status.requested), 8'(`CSM_RESET_SRC));
    prot(1'b1, 8'(`CSM_SRC_FRC));
    prot(1'b0, 8'h01);
    waitc(4);
    chk("switchReq", 8'(status.switchReq), 8'h00);
    chk("current", 8'(status.current), 8'(`CSM_SRC_FRC));
    prot(1'b1, 8'(`CSM_SRC_PRI_PLL));
    waitc(3);
    chk("requested", 8'(status.requested), 8'(`CSM_SRC_PRI_PLL));
    prot(1'b0, 8'h01);
    waitc(6);
    chk("switchReq", 8'(status.switchReq), 8'h01);
    chk("pllLock", 8'(status.pllLock), 8'h00);
    osc_startup_timer_done <= 1'b1;
    oscRunning <= 8'h25;
    waitc(6);
    chk("switchReq", 8'(status.switchReq), 8'h01);
    pllLocked <= 1'b1;
    ticks = 0;
    for (int i = 0; i < 80 && status.switchReq !== 1'b0; i++) begin
      waitc(1);
      ticks += int'(newClkTick);
    end
    chk("ticks", 8'(ticks >= 10 && ticks <= 12), 8'h01);
    waitc(2);
    chk("current", 8'(status.current), 8'(`CSM_SRC_PRI_PLL));
    chk("sysClkSel", 8'(sysClkSel), 8'(`CSM_SRC_PRI_PLL));
    chk("oscEnable", 8'(oscEnable & 8'h25), 8'h24);
    actOn <= 1'b0;
    trapSeen = 1'b0;
    repeat (60) begin
      waitc(1);
      trapSeen |= clockFailTrap;
    end
    chk("trap", 8'(trapSeen), 8'h01);
    chk("sysClkSel", 8'(sysClkSel), 8'(`CSM_SRC_FRC_PLL));
    chk("clockFail", 8'(status.clockFail), 8'h01);
    actOn <= 1'b1;
    prot(1'b1, 8'(`CSM_SRC_FRC));
    prot(1'b0, 8'h01);
    waitc(3);
    for (int i = 0; i < 80 && status.switchReq !== 1'b0; i++) begin
      waitc(1);
    end
    waitc(2);
    chk("current", 8'(status.current), 8'(`CSM_SRC_FRC));
    chk("clockFail", 8'(status.clockFail), 8'h00);
    endSim();
  end
endmodule : tb_top
